// file: bsr_cfg.svh
`ifndef BSR_CFG_SVH
`define BSR_CFG_SVH
`define BSR_PM_ADDR_W 12
`define BSR_PAGE_W 8
`define BSR_DM_ADDR_W 8
`define BSR_DATA_W 8
`define BSR_PM_WORD_W 16
`define BSR_BIT_SEL_W 3
`define BSR_LAST_PAGE 4'hf
`define BSR_TABLE_HIGH_LATCH_RESET 8'h00
`define BSR_SKIP_CYCLES 2
`endif

// file: bsr_exec.sv
`timescale 1ns/1ps
`include "bsr_cfg.svh"
// Contract
// - Bit-skip tests chosen data bit; if zero, the next instruction is discarded.
// - Taken skip lasts two cycles, dummy operation replaces the skipped instruction.
// - If tested bit is one, execution continues with the next instruction.
// - Current-page table read fetches word at pointer within the current page.
// - Table read writes low byte to data memory, high byte to table-high latch.
// - Last-page table read fetches the word from the last program page.
module bsr_exec #(
    parameter int PM_ADDR_W = `BSR_PM_ADDR_W,
    parameter int PAGE_W = `BSR_PAGE_W,
    parameter int DATA_W = `BSR_DATA_W,
    parameter int PM_WORD_W = `BSR_PM_WORD_W,
    parameter int BIT_SEL_W = `BSR_BIT_SEL_W
) (
    input wire logic clock,
    input wire logic nrst,
    input wire bsr_pkg::bsr_instr_t instr,
    input wire logic [DATA_W-1:0] dmRdData,
    input wire logic [PAGE_W-1:0] tablePointer,
    input wire logic [PM_ADDR_W-1:0] pcAddr,
    input wire logic [PM_WORD_W-1:0] pmRdData,
    output logic [`BSR_DM_ADDR_W-1:0] dmRdAddr,
    output bsr_pkg::bsr_dm_wr_t dmWr,
    output logic [PM_ADDR_W-1:0] pmRdAddr,
    output logic pmRdEn,
    output logic [DATA_W-1:0] tableHighLatch,
    output logic flushNext,
    output logic busy,
    output logic flagWe
);
    import bsr_pkg::*;

    typedef enum logic [1:0] {
        BSR_ST_IDLE,
        BSR_ST_TABLE,
        BSR_ST_DUMMY
    } bsr_state_t;

    // Upper program address bits that name the page
    localparam int PAGE_HI_W = PM_ADDR_W - PAGE_W;

    logic rstSync_n;
    logic [BIT_SEL_W-1:0] bitSel;
    logic [DATA_W-1:0] bitHit;
    logic testedBitSet;
    logic accept;
    logic isSkip;
    logic isTableCur;
    logic isTableLast;

    bsr_state_t state_reg, state_next;
    logic [`BSR_DM_ADDR_W-1:0] dmRdAddr_reg, dmRdAddr_next;
    logic [`BSR_DM_ADDR_W-1:0] tgt_reg, tgt_next;
    bsr_dm_wr_t dmWr_reg, dmWr_next;
    logic [PM_ADDR_W-1:0] pmRdAddr_reg, pmRdAddr_next;
    logic pmRdEn_reg, pmRdEn_next;
    logic [DATA_W-1:0] tbh_reg, tbh_next;
    logic flush_reg, flush_next;
    logic busy_reg, busy_next;
    logic flagWe_reg, flagWe_next;

    bsr_reset_sync uSync (
        .clock(clock),
        .nrst(nrst),
        .syncRst_n(rstSync_n)
    );

    // Data memory answers combinationally to the address of the issued instruction
    assign bitSel = instr.bitSel;

    // One lane per data bit; only the selected lane can be high
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi = gi + 1) begin : gBit
            assign bitHit[gi] = dmRdData[gi] & (bitSel == BIT_SEL_W'(gi));
        end
    endgenerate

    assign testedBitSet = |bitHit;
    // Second slot of a two-cycle instruction takes no new work
    assign accept = instr.valid && (state_reg == BSR_ST_IDLE);
    assign isSkip = accept && (instr.op == BSR_OP_SKIP_IF_BIT_CLEAR);
    assign isTableCur = accept && (instr.op == BSR_OP_READ_TABLE_CURRENT_PAGE);
    assign isTableLast = accept && (instr.op == BSR_OP_READ_TABLE_LAST_PAGE);

    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BSR_ST_IDLE: begin
                if (isSkip && !testedBitSet) begin
                    state_next = BSR_ST_DUMMY;
                end else if (isTableCur || isTableLast) begin
                    state_next = BSR_ST_TABLE;
                end
            end
            BSR_ST_TABLE: begin
                state_next = BSR_ST_IDLE;
            end
            BSR_ST_DUMMY: begin
                // Flushed instruction lands here and is dropped
                state_next = BSR_ST_IDLE;
            end
            default: begin
                state_next = BSR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg <= BSR_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Program fetch; the address holds until the next table read
    always_comb begin
        pmRdAddr_next = pmRdAddr_reg;
        pmRdEn_next = 1'b0;
        tgt_next = tgt_reg;
        if (isTableCur) begin
            pmRdAddr_next = {pcAddr[PM_ADDR_W-1:PAGE_W], tablePointer};
            pmRdEn_next = 1'b1;
            tgt_next = instr.addr;
        end else if (isTableLast) begin
            pmRdAddr_next = {PAGE_HI_W'(`BSR_LAST_PAGE), tablePointer};
            pmRdEn_next = 1'b1;
            tgt_next = instr.addr;
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pmRdAddr_reg <= '0;
            pmRdEn_reg <= 1'b0;
            tgt_reg <= '0;
        end else begin
            pmRdAddr_reg <= pmRdAddr_next;
            pmRdEn_reg <= pmRdEn_next;
            tgt_reg <= tgt_next;
        end
    end

    // Program memory answers within the strobe cycle, taken on its closing edge
    always_comb begin
        dmWr_next = '0;
        tbh_next = tbh_reg;
        if (state_reg == BSR_ST_TABLE) begin
            dmWr_next.we = 1'b1;
            dmWr_next.addr = tgt_reg;
            dmWr_next.data = pmRdData[DATA_W-1:0];
            tbh_next = pmRdData[PM_WORD_W-1:DATA_W];
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            dmWr_reg <= '0;
            tbh_reg <= `BSR_TABLE_HIGH_LATCH_RESET;
        end else begin
            dmWr_reg <= dmWr_next;
            tbh_reg <= tbh_next;
        end
    end

    // Skip and second-slot indication towards the fetch pipeline
    always_comb begin
        flush_next = 1'b0;
        busy_next = 1'b0;
        if (isSkip) begin
            if (!testedBitSet) begin
                flush_next = 1'b1;
                busy_next = 1'b1;
            end else begin
                flush_next = 1'b0;
            end
        end else if (isTableCur || isTableLast) begin
            busy_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            flush_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            flush_reg <= flush_next;
            busy_reg <= busy_next;
        end
    end

    always_comb begin
        dmRdAddr_next = instr.addr;
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            dmRdAddr_reg <= '0;
        end else begin
            dmRdAddr_reg <= dmRdAddr_next;
        end
    end

    // These instructions own no status flag, so the strobe never rises
    always_comb begin
        flagWe_next = 1'b0;
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            flagWe_reg <= 1'b0;
        end else begin
            flagWe_reg <= flagWe_next;
        end
    end

    assign dmRdAddr = dmRdAddr_reg;
    assign dmWr = dmWr_reg;
    assign pmRdAddr = pmRdAddr_reg;
    assign pmRdEn = pmRdEn_reg;
    assign tableHighLatch = tbh_reg;
    assign flushNext = flush_reg;
    assign busy = busy_reg;
    assign flagWe = flagWe_reg;
endmodule

// file: bsr_exec_sva.sv
`timescale 1ns/1ps
`include "bsr_cfg.svh"
module bsr_exec_sva (
    input logic clock,
    input logic nrst,
    input bsr_pkg::bsr_instr_t instr,
    input logic [`BSR_DATA_W-1:0] dmRdData,
    input logic [`BSR_PAGE_W-1:0] tablePointer,
    input logic [`BSR_PM_ADDR_W-1:0] pcAddr,
    input logic [`BSR_PM_WORD_W-1:0] pmRdData,
    input bsr_pkg::bsr_dm_wr_t dmWr,
    input logic [`BSR_PM_ADDR_W-1:0] pmRdAddr,
    input logic pmRdEn,
    input logic [`BSR_DATA_W-1:0] tableHighLatch,
    input logic flushNext,
    input logic busy,
    input logic flagWe
);
    import bsr_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Busy marks the refused second cycle
    wire go = instr.valid && !busy;
    wire bitVal = dmRdData[instr.bitSel];
    wire [`BSR_PM_ADDR_W-`BSR_PAGE_W-1:0] curPage = pcAddr[`BSR_PM_ADDR_W-1:`BSR_PAGE_W];
    property p_skip; go && instr.op == BSR_OP_SKIP_IF_BIT_CLEAR && !bitVal |=> flushNext && busy;
    endproperty
    a_skip: assert property (p_skip) else $error("taken skip not flagged");
    property p_two; flushNext |-> busy ##1 (!flushNext && !busy); endproperty
    a_two: assert property (p_two) else $error("skip not two cycles");
    property p_noskip; go && instr.op == BSR_OP_SKIP_IF_BIT_CLEAR && bitVal |=> !flushNext && !busy;
    endproperty
    a_noskip: assert property (p_noskip) else $error("skip taken on set bit");
    property p_cur; go && instr.op == BSR_OP_READ_TABLE_CURRENT_PAGE |=>
        pmRdEn && pmRdAddr == {$past(curPage), $past(tablePointer)}; endproperty
    a_cur: assert property (p_cur) else $error("current page fetch wrong");
    property p_low; pmRdEn |=> dmWr.we && {tableHighLatch, dmWr.data} == $past(pmRdData);
    endproperty
    a_low: assert property (p_low) else $error("table bytes misplaced");
    property p_last; go && instr.op == BSR_OP_READ_TABLE_LAST_PAGE |=>
        pmRdEn && pmRdAddr == {`BSR_LAST_PAGE, $past(tablePointer)}; endproperty
    a_last: assert property (p_last) else $error("last page fetch wrong");
    property p_flag; go |=> !flagWe ##1 !flagWe; endproperty
    a_flag: assert property (p_flag) else $error("flag write seen");
    property p_refuse; busy && instr.valid |=> !pmRdEn && !flushNext; endproperty
    a_refuse: assert property (p_refuse) else $error("second slot took new work");
    property p_dest; go && (instr.op == BSR_OP_READ_TABLE_CURRENT_PAGE ||
        instr.op == BSR_OP_READ_TABLE_LAST_PAGE) |=> ##1 dmWr.addr == $past(instr.addr, 2);
    endproperty
    a_dest: assert property (p_dest) else $error("low byte sent to wrong location");
endmodule
bind bsr_exec bsr_exec_sva chk (
    .clock(clock),
    .nrst(nrst),
    .instr(instr),
    .dmRdData(dmRdData),
    .tablePointer(tablePointer),
    .pcAddr(pcAddr),
    .pmRdData(pmRdData),
    .dmWr(dmWr),
    .pmRdAddr(pmRdAddr),
    .pmRdEn(pmRdEn),
    .tableHighLatch(tableHighLatch),
    .flushNext(flushNext),
    .busy(busy),
    .flagWe(flagWe)
);

// file: bsr_pkg.sv
`include "bsr_cfg.svh"
package bsr_pkg;
    typedef enum logic [1:0] {
        BSR_OP_NONE,
        BSR_OP_SKIP_IF_BIT_CLEAR,
        BSR_OP_READ_TABLE_CURRENT_PAGE,
        BSR_OP_READ_TABLE_LAST_PAGE
    } bsr_op_t;

    typedef struct packed {
        logic valid;
        bsr_op_t op;
        logic [`BSR_DM_ADDR_W-1:0] addr;
        logic [`BSR_BIT_SEL_W-1:0] bitSel;
    } bsr_instr_t;

    typedef struct packed {
        logic we;
        logic [`BSR_DM_ADDR_W-1:0] addr;
        logic [`BSR_DATA_W-1:0] data;
    } bsr_dm_wr_t;
endpackage

// file: bsr_reset_sync.sv
`timescale 1ns/1ps
module bsr_reset_sync (
    input wire logic clock,
    input wire logic nrst,
    output logic syncRst_n
);
    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncRst_n = stage2_reg;
endmodule

// file: test_bit_skip_and_table_read.sv
`timescale 1ns/1ps
module test_bit_skip_and_table_read;
    import bsr_pkg::*;
    logic clock, nrst, pmRdEn, flushNext, busy, flagWe;
    bsr_instr_t instr;
    logic [7:0] tablePointer, tableHighLatch, dmRdAddr;
    logic [11:0] pcAddr, pmRdAddr;
    logic [15:0] pmRdData;
    bsr_dm_wr_t dmWr;
    int failCount = 0, checks = 0, cycles = 0;
    // Data memory stand-in: each location holds its own address
    bsr_exec dut (.clock(clock), .nrst(nrst), .instr(instr), .dmRdData(instr.addr),
        .tablePointer(tablePointer), .pcAddr(pcAddr), .pmRdData(pmRdData), .dmRdAddr(dmRdAddr),
        .dmWr(dmWr), .pmRdAddr(pmRdAddr), .pmRdEn(pmRdEn), .tableHighLatch(tableHighLatch),
        .flushNext(flushNext), .busy(busy), .flagWe(flagWe));
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            failCount++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [16:0] got, exp);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic issue(input bsr_op_t op, input logic [7:0] a, input logic [2:0] b);
        @(negedge clock);
        instr = '{1'b1, op, a, b};
        @(negedge clock);
        instr = '0;
    endtask
    task automatic skipTaken;
        issue(BSR_OP_SKIP_IF_BIT_CLEAR, 8'hf7, 3'h3);
        chk("flushNext", flushNext, 1'b1);
        chk("busy", busy, 1'b1);
        chk("dmRdAddr", dmRdAddr, 8'hf7);
        @(negedge clock);
        chk("busy", busy, 0);
        $display("skip taken done");
    endtask
    task automatic skipBackToBack;
        @(negedge clock);
        instr = '{1'b1, BSR_OP_SKIP_IF_BIT_CLEAR, 8'h08, 3'h3};
        @(negedge clock);
        chk("flushNext", flushNext, 1'b0);
        chk("busy", busy, 1'b0);
        // Bit 0 here is clear, so the skip right behind must still be taken
        instr.addr = 8'hfe;
        instr.bitSel = 3'h0;
        @(negedge clock);
        instr = '0;
        chk("flushNext", flushNext, 1'b1);
        @(negedge clock);
        chk("busy", busy, 1'b0);
        $display("skip not taken done");
    endtask
    task automatic dummySlot;
        @(negedge clock);
        instr = '{1'b1, BSR_OP_SKIP_IF_BIT_CLEAR, 8'h10, 3'h0};
        @(negedge clock);
        // Lands in the dummy slot and must be dropped
        instr = '{1'b1, BSR_OP_READ_TABLE_LAST_PAGE, 8'h44, 3'h0};
        @(negedge clock);
        instr = '0;
        chk("pmRdEn", pmRdEn, 1'b0);
        chk("flushNext", flushNext, 1'b0);
        chk("busy", busy, 1'b0);
        // No-op with a clear bit under it must not skip
        issue(BSR_OP_NONE, 8'h00, 3'h0);
        chk("flushNext", flushNext, 1'b0);
        $display("dummy slot done");
    endtask
    task automatic tableRead(input bsr_op_t op, input logic [15:0] w, input logic [3:0] pg);
        pmRdData = w;
        issue(op, 8'h33, 3'h0);
        chk("pmRdAddr", {pmRdEn, pmRdAddr}, {1'b1, pg, 8'h7c});
        @(negedge clock);
        chk("dmWr", dmWr, {1'b1, 8'h33, w[7:0]});
        chk("tableHighLatch", tableHighLatch, w[15:8]);
        chk("flagWe", flagWe, 0);
        $display("table read done");
    endtask
    initial begin
        nrst = 0;
        instr = '0;
        pcAddr = 12'h3a5;
        tablePointer = 8'h7c;
        pmRdData = 16'h0000;
        repeat (5) @(negedge clock);
        nrst = 1;
        repeat (3) @(negedge clock);
        skipTaken();
        skipBackToBack();
        dummySlot();
        tableRead(BSR_OP_READ_TABLE_CURRENT_PAGE, 16'hbe42, 4'h3);
        tableRead(BSR_OP_READ_TABLE_LAST_PAGE, 16'h5ac1, 4'hf);
        results();
    end
endmodule
